// file: include/isc_params.svh
`ifndef ISC_PARAMS_SVH
`define ISC_PARAMS_SVH

// register byte addresses
`define ISC_CTRL_ADDR     32'hffff0928
`define ISC_STAT_ADDR     32'hffff092c
`define ISC_OWN_ADDR      32'hffff0930
`define ISC_ALT_ADDR      32'hffff0934
`define ISC_ISTS_ADDR     32'hffff0938
`define ISC_IMSK_ADDR     32'hffff093c
`define ISC_RXD_ADDR      32'hffff0940
`define ISC_TXD_ADDR      32'hffff0944

// reset values
`define ISC_CTRL_RST      16'h0000
`define ISC_STAT_RST      16'h0000

// slave_control fields
`define ISC_C_SEN         0
`define ISC_C_A10         1
`define ISC_C_GCEN        2
`define ISC_C_HGCEN       3
`define ISC_C_GCCLR       4
`define ISC_C_ETX         5
`define ISC_C_SSEN        6
`define ISC_C_NACK        7
`define ISC_C_MASK        16'h07ff

// slave_status fields
`define ISC_S_STA         14
`define ISC_S_REPS        13
`define ISC_S_SS          10
`define ISC_S_GCID        8
`define ISC_S_GCF         7

// interrupt status / mask bits
`define ISC_I_TX          0
`define ISC_I_RX          1
`define ISC_I_STOP        2
`define ISC_I_GC          3

// general call codes
`define ISC_GC_ADDR       8'h00
`define ISC_GC_RESET      8'h06
`define ISC_GC_PROG       8'h04
`define ISC_GCID_NONE     2'h0
`define ISC_GCID_RST      2'h1
`define ISC_GCID_PROG     2'h2
`define ISC_GCID_ALT      2'h3
`define ISC_TEN_PREFIX    5'h1e

// bus responses
`define ISC_RESP_OKAY     2'h0
`define ISC_RESP_SLVERR   2'h2

`endif

// file: include/isc_pkg.sv
package isc_pkg;
	typedef enum logic [2:0] {
		ISC_IDLE,
		ISC_ADDR,
		ISC_ADDR_LO,
		ISC_RX,
		ISC_TX,
		ISC_ACK,
		ISC_MACK,
		ISC_IGNORE
	} isc_state_t;

	typedef logic [15:0] isc_reg_t;
endpackage : isc_pkg

// file: hdl/isc_pin_sync.sv
`timescale 1ns/1ps
module isc_pin_sync (
	input  wire logic clk_sys,
	input  wire logic rst_n,
	input  wire logic scl_i,
	input  wire logic sda_i,
	output logic      scl_s,
	output logic      sda_s,
	output logic      scl_rise,
	output logic      scl_fall,
	output logic      start_det,
	output logic      stop_det
);
	logic [1:0] scl_m_q;
	logic [1:0] sda_m_q;
	logic       scl_p_q;
	logic       sda_p_q;

	// two stages, idle bus level is high
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			scl_m_q <= 2'h3;
			sda_m_q <= 2'h3;
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else begin
			scl_m_q <= {scl_m_q[0], scl_i};
			sda_m_q <= {sda_m_q[0], sda_i};
			scl_p_q <= scl_m_q[1];
			sda_p_q <= sda_m_q[1];
		end
	end

	// edges seen only past the second stage
	assign scl_s     = scl_m_q[1];
	assign sda_s     = sda_m_q[1];
	assign scl_rise  = scl_m_q[1] & ~scl_p_q;
	assign scl_fall  = ~scl_m_q[1] & scl_p_q;
	assign start_det = scl_m_q[1] & scl_p_q & sda_p_q & ~sda_m_q[1];
	assign stop_det  = scl_m_q[1] & scl_p_q & ~sda_p_q & sda_m_q[1];
endmodule : isc_pin_sync

// file: hdl/isc_axil_slave.sv
`timescale 1ns/1ps
`include "isc_params.svh"
module isc_axil_slave (
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic             wr_en,
	output logic [31:0]      wr_addr,
	output logic [31:0]      wr_data,
	output logic [3:0]       wr_strb,
	input  wire logic        wr_ok,
	output logic             rd_en,
	input  wire logic [31:0] rd_data,
	input  wire logic        rd_ok
);
	// address and data latch independently, either order
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			wr_addr       <= 32'h0;
			wr_data       <= 32'h0;
			wr_strb       <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				s_axi_awready <= 1'b0;
				wr_addr       <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				s_axi_wready <= 1'b0;
				wr_data      <= s_axi_wdata;
				wr_strb      <= s_axi_wstrb;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// one-cycle write strobe once both halves are in
	assign wr_en = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `ISC_RESP_OKAY;
		end else if (wr_en) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_ok ? `ISC_RESP_OKAY : `ISC_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// read answers the cycle after the address is taken
	assign rd_en = s_axi_arvalid & s_axi_arready;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0;
			s_axi_rresp   <= `ISC_RESP_OKAY;
		end else if (rd_en) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_data;
			s_axi_rresp   <= rd_ok ? `ISC_RESP_OKAY : `ISC_RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
		end
	end
endmodule : isc_axil_slave

// file: hdl/isc_slave_ctrl.sv
// Notes on behaviour
// R01: clearing the stretch bit releases SCL at once.
// R02: early bit set: transmit request right after SCL rise of the R/W bit.
// R03: early bit clear: transmit request right after SCL fall of the R/W bit.
// R04: writing one to the clear bit wipes general call flag and identifier.
// R05: software keeps the general call clear bit at zero otherwise.
// R06: with both call enables set, compare byte after address 0x00 with alternate ID.
// R07: equal byte flags a hardware general call.
// R08: software writes alternate ID bit 0 as one.
// R09: call enable set: acknowledge write to 0x00, then accept the next byte.
// R10: data byte 0x06 after general call resets the slave interface.
// R11: data byte 0x04 after general call sets the general call flag.
// R12: software reprograms own address after a program-address call.
// R13: wide address mode one selects 10-bit address matching.
// R14: wide address mode zero selects 7-bit address matching.
// R15: slave works only while slave enable is set.
// R16: slave status is 16 bits at 0xffff092c, reset 0x0000.
// R17: stretch enabled holds SCL low, now if low, else from next fall.
// R18: identifier 00 none, 01 reset, 10 program, 11 alternate match.
// R19: disabled slave never acknowledges, stretches or sets interrupt status; irq is not gated by enable and holds for pending status.
`timescale 1ns/1ps
`include "isc_params.svh"
module isc_slave_ctrl (
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        scl_i,
	output logic             scl_o,
	output logic             scl_oe,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe,
	output logic             irq
);
	import isc_pkg::*;

	logic        wr_en, wr_ok, rd_en, rd_ok;
	logic [31:0] wr_addr, wr_data, rd_data;
	logic [3:0]  wr_strb;
	logic        scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det;

	isc_reg_t    slave_control_q;
	logic [9:0]  own_addr_q;
	logic [7:0]  alternate_id_q, rx_data_q, tx_data_q;
	logic [3:0]  irq_sts_q, irq_mask_q;
	isc_state_t  st_q, nxt_q;
	logic [3:0]  bitcnt_q;
	logic [7:0]  shift_q, tx_sh_q;
	logic        rw_q, gc_phase_q, ten_hit_q, mack_q;
	logic        sta_q, reps_q, stop_q, gc_flag_q;
	logic [1:0]  gencall_identifier_q, gc_code_q;
	logic        ev_tx_q, ev_rx_q, ev_stop_q, ev_gc_q;
	logic        hold_q, sda_drv_q;

	wire slave_enable        = slave_control_q[`ISC_C_SEN];
	wire wide_address_mode   = slave_control_q[`ISC_C_A10];
	wire gencall_enable      = slave_control_q[`ISC_C_GCEN];
	wire hw_gencall_enable   = slave_control_q[`ISC_C_HGCEN];
	wire early_tx_irq_select = slave_control_q[`ISC_C_ETX];
	wire clock_stretch_enable = slave_control_q[`ISC_C_SSEN];
	wire nack_next           = slave_control_q[`ISC_C_NACK];

	// byte-lane merge of a 16-bit register
	function automatic isc_reg_t merge16(isc_reg_t old, logic [31:0] d, logic [3:0] s);
		merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction : merge16

	// 7-bit or 10-bit first byte hit, read or write
	function automatic logic addr_hit(logic [7:0] b, logic wide, logic [9:0] own);
		if (wide) // [R13]
			addr_hit = (b[7:3] == `ISC_TEN_PREFIX) && (b[2:1] == own[9:8]);
		else // [R14]
			addr_hit = (b[7:1] == own[6:0]);
	endfunction : addr_hit

	// a first byte that turns the slave into transmitter
	function automatic logic read_hit(logic [7:0] b, logic wide, logic [9:0] own, logic th);
		read_hit = b[0] && addr_hit(b, wide, own) && (!wide || th);
	endfunction : read_hit

	isc_axil_slave u_bus (
		.clk_sys       (clk_sys),
		.rst_n         (rst_n),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.wr_en         (wr_en),
		.wr_addr       (wr_addr),
		.wr_data       (wr_data),
		.wr_strb       (wr_strb),
		.wr_ok         (wr_ok),
		.rd_en         (rd_en),
		.rd_data       (rd_data),
		.rd_ok         (rd_ok)
	);

	isc_pin_sync u_sync (
		.clk_sys   (clk_sys),
		.rst_n     (rst_n),
		.scl_i     (scl_i),
		.sda_i     (sda_i),
		.scl_s     (scl_s),
		.sda_s     (sda_s),
		.scl_rise  (scl_rise),
		.scl_fall  (scl_fall),
		.start_det (start_det),
		.stop_det  (stop_det)
	);

	wire wr_ctrl = wr_en && (wr_addr == `ISC_CTRL_ADDR);
	wire wr_ists = wr_en && (wr_addr == `ISC_ISTS_ADDR);
	wire rd_stat = rd_en && (s_axi_araddr == `ISC_STAT_ADDR);
	wire gc_clr  = wr_ctrl && wr_strb[0] && wr_data[`ISC_C_GCCLR];

	// software-written configuration; status write is accepted and dropped
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			slave_control_q <= `ISC_CTRL_RST;
			own_addr_q      <= 10'h0;
			alternate_id_q  <= 8'h0;
			irq_mask_q      <= 4'h0;
			tx_data_q       <= 8'h0;
		end else if (wr_en) begin
			case (wr_addr)
				`ISC_CTRL_ADDR:
					slave_control_q <= merge16(slave_control_q, wr_data, wr_strb)
						& `ISC_C_MASK;
				`ISC_OWN_ADDR:
					own_addr_q <= 10'(merge16({6'h0, own_addr_q}, wr_data, wr_strb));
				`ISC_ALT_ADDR: if (wr_strb[0]) alternate_id_q <= wr_data[7:0];
				`ISC_IMSK_ADDR: if (wr_strb[0]) irq_mask_q <= wr_data[3:0];
				`ISC_TXD_ADDR: if (wr_strb[0]) tx_data_q <= wr_data[7:0];
				default: ;
			endcase
		end
	end

	// decode and read mux; unmapped answers with an error
	always_comb begin
		rd_data = 32'h0;
		rd_ok   = 1'b1;
		case (s_axi_araddr)
			`ISC_CTRL_ADDR: rd_data = {16'h0, slave_control_q};
			`ISC_STAT_ADDR: begin
				rd_data[`ISC_S_STA]                 = sta_q; // [R16]
				rd_data[`ISC_S_REPS]                = reps_q;
				rd_data[`ISC_S_SS]                  = stop_q;
				rd_data[`ISC_S_GCID+1:`ISC_S_GCID]  = gencall_identifier_q;
				rd_data[`ISC_S_GCF]                 = gc_flag_q;
			end
			`ISC_OWN_ADDR:  rd_data = {22'h0, own_addr_q};
			`ISC_ALT_ADDR:  rd_data = {24'h0, alternate_id_q};
			`ISC_ISTS_ADDR: rd_data = {28'h0, irq_sts_q};
			`ISC_IMSK_ADDR: rd_data = {28'h0, irq_mask_q};
			`ISC_RXD_ADDR:  rd_data = {24'h0, rx_data_q};
			`ISC_TXD_ADDR:  rd_data = {24'h0, tx_data_q};
			default:        rd_ok = 1'b0;
		endcase
	end

	always_comb begin
		case (wr_addr)
			`ISC_CTRL_ADDR, `ISC_STAT_ADDR, `ISC_OWN_ADDR, `ISC_ALT_ADDR,
			`ISC_ISTS_ADDR, `ISC_IMSK_ADDR, `ISC_RXD_ADDR, `ISC_TXD_ADDR: wr_ok = 1'b1;
			default: wr_ok = 1'b0;
		endcase
	end

	// byte engine; disabling drops it to idle at once
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= ISC_IDLE;
			nxt_q <= ISC_IDLE;
			bitcnt_q <= 4'h0;
			shift_q <= 8'h0;
			tx_sh_q <= 8'hff;
			rw_q <= 1'b0;
			gc_phase_q <= 1'b0;
			ten_hit_q <= 1'b0;
			mack_q <= 1'b0;
			sta_q <= 1'b0;
			reps_q <= 1'b0;
			sda_drv_q <= 1'b0;
			rx_data_q <= 8'h0;
			gc_code_q <= `ISC_GCID_NONE;
			{ev_tx_q, ev_rx_q, ev_stop_q, ev_gc_q} <= 4'h0;
		end else begin
			{ev_tx_q, ev_rx_q, ev_stop_q, ev_gc_q} <= 4'h0;
			if (!slave_enable) begin // [R15] [R19]
				st_q <= ISC_IDLE;
				sda_drv_q <= 1'b0;
				sta_q <= 1'b0;
				reps_q <= 1'b0;
				ten_hit_q <= 1'b0;
				gc_phase_q <= 1'b0;
			end else if (stop_det) begin
				st_q <= ISC_IDLE;
				sda_drv_q <= 1'b0;
				ev_stop_q <= sta_q;
				sta_q <= 1'b0;
				reps_q <= 1'b0;
				ten_hit_q <= 1'b0;
				gc_phase_q <= 1'b0;
			end else if (start_det) begin
				st_q <= ISC_ADDR;
				bitcnt_q <= 4'h0;
				sda_drv_q <= 1'b0;
				reps_q <= reps_q | sta_q;
				gc_phase_q <= 1'b0;
			end else if (scl_rise) begin
				bitcnt_q <= bitcnt_q + 4'h1;
				shift_q <= {shift_q[6:0], sda_s};
				if (st_q == ISC_MACK)
					mack_q <= ~sda_s;
				// early request while the read bit is still high
				if (st_q == ISC_ADDR && bitcnt_q == 4'h7 && early_tx_irq_select &&
				    read_hit({shift_q[6:0], sda_s}, wide_address_mode, own_addr_q, ten_hit_q))
					ev_tx_q <= 1'b1; // [R02]
			end else if (scl_fall) begin
				case (st_q)
					ISC_ADDR: if (bitcnt_q == 4'h8) begin
						if (addr_hit(shift_q, wide_address_mode, own_addr_q) &&
						    (!shift_q[0] || !wide_address_mode || ten_hit_q)) begin
							sda_drv_q <= 1'b1;
							st_q <= ISC_ACK;
							sta_q <= 1'b1;
							rw_q <= shift_q[0];
							if (shift_q[0]) begin
								nxt_q <= ISC_TX;
								ev_tx_q <= ~early_tx_irq_select; // [R03]
							end else
								nxt_q <= wide_address_mode ? ISC_ADDR_LO : ISC_RX;
						end else if (gencall_enable && shift_q == `ISC_GC_ADDR) begin
							sda_drv_q <= 1'b1; // [R09]
							st_q <= ISC_ACK;
							sta_q <= 1'b1;
							gc_phase_q <= 1'b1;
							nxt_q <= ISC_RX;
						end else
							st_q <= ISC_IGNORE; // [R19]
					end
					ISC_ADDR_LO: if (bitcnt_q == 4'h8) begin
						if (shift_q == own_addr_q[7:0]) begin
							sda_drv_q <= 1'b1;
							st_q <= ISC_ACK;
							ten_hit_q <= 1'b1;
							nxt_q <= ISC_RX;
						end else
							st_q <= ISC_IGNORE;
					end
					ISC_RX: if (bitcnt_q == 4'h8) begin
						rx_data_q <= shift_q;
						ev_rx_q <= 1'b1;
						sda_drv_q <= ~nack_next;
						st_q <= nack_next ? ISC_IGNORE : ISC_ACK;
						nxt_q <= ISC_RX;
						if (gc_phase_q) begin
							gc_phase_q <= 1'b0;
							if (hw_gencall_enable && shift_q == alternate_id_q) begin
								ev_gc_q <= 1'b1; // [R06] [R07]
								gc_code_q <= `ISC_GCID_ALT;
							end else if (shift_q == `ISC_GC_RESET) begin
								ev_gc_q <= 1'b1;
								gc_code_q <= `ISC_GCID_RST;
								nxt_q <= ISC_IGNORE; // [R10]
								sta_q <= 1'b0;
								reps_q <= 1'b0;
								ten_hit_q <= 1'b0;
							end else if (shift_q == `ISC_GC_PROG) begin
								ev_gc_q <= 1'b1; // [R11]
								gc_code_q <= `ISC_GCID_PROG;
							end
						end
					end
					ISC_ACK: begin
						bitcnt_q <= 4'h0;
						st_q <= nxt_q;
						sda_drv_q <= (nxt_q == ISC_TX) && !tx_data_q[7];
						tx_sh_q <= {tx_data_q[6:0], 1'b1};
					end
					ISC_TX: if (bitcnt_q == 4'h8) begin
						sda_drv_q <= 1'b0;
						st_q <= ISC_MACK;
					end else begin
						sda_drv_q <= !tx_sh_q[7];
						tx_sh_q <= {tx_sh_q[6:0], 1'b1};
					end
					ISC_MACK: begin
						// master ack asks for the next byte
						bitcnt_q <= 4'h0;
						st_q <= mack_q ? ISC_TX : ISC_IGNORE;
						ev_tx_q <= mack_q;
						sda_drv_q <= mack_q && !tx_data_q[7];
						tx_sh_q <= {tx_data_q[6:0], 1'b1};
					end
					default: sda_drv_q <= 1'b0;
				endcase
			end
		end
	end

	// stretch: grab while low, else on the next fall; drop on clear
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			hold_q <= 1'b0;
		else if (!clock_stretch_enable || !slave_enable)
			hold_q <= 1'b0; // [R01] [R19]
		else if (!scl_s || scl_fall)
			hold_q <= 1'b1; // [R17]
	end

	// stop flag clears on status read; a new stop wins
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			stop_q <= 1'b0;
		else if (ev_stop_q)
			stop_q <= 1'b1;
		else if (rd_stat)
			stop_q <= 1'b0;
	end

	// general call flag and identifier; a fresh call beats the clear
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			gc_flag_q <= 1'b0;
			gencall_identifier_q <= `ISC_GCID_NONE;
		end else if (ev_gc_q) begin
			gc_flag_q <= 1'b1;
			gencall_identifier_q <= gc_code_q; // [R18]
		end else if (gc_clr) begin
			gc_flag_q <= 1'b0; // [R04]
			gencall_identifier_q <= `ISC_GCID_NONE;
		end
	end

	// sticky events, write one to clear, set wins
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			irq_sts_q <= 4'h0;
		else
			irq_sts_q <= (irq_sts_q & ~(wr_ists && wr_strb[0] ? wr_data[3:0] : 4'h0))
				| {ev_gc_q, ev_stop_q, ev_rx_q, ev_tx_q};
	end

	// pins and interrupt straight from flops; open-drain level stays low
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			scl_o  <= 1'b0;
			sda_o  <= 1'b0;
			scl_oe <= 1'b0;
			sda_oe <= 1'b0;
			irq    <= 1'b0;
		end else begin
			scl_o  <= 1'b0;
			sda_o  <= 1'b0;
			scl_oe <= hold_q;
			sda_oe <= sda_drv_q && slave_enable;
			irq    <= |(irq_sts_q & irq_mask_q);
		end
	end
endmodule : isc_slave_ctrl

// file: verification/isc_slave_ctrl_checker.sv
`timescale 1ns/1ps
`include "isc_params.svh"
module isc_slave_ctrl_checker (
	input wire logic        clk_sys,
	input wire logic        rst_n,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0]  s_axi_wstrb,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        scl_i,
	input wire logic        scl_oe,
	input wire logic        sda_oe
);
	logic       en_q;
	logic       ss_q;
	logic [1:0] off_q;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// shadow of enable and stretch, one edge ahead of the register
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			en_q <= 1'b0;
			ss_q <= 1'b0;
		end else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
			&& s_axi_awaddr == `ISC_CTRL_ADDR && s_axi_wstrb[0]) begin
			en_q <= s_axi_wdata[`ISC_C_SEN];
			ss_q <= s_axi_wdata[`ISC_C_SSEN];
		end
	end
	// cycles since disable, saturating
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			off_q <= 2'h0;
		else if (en_q)
			off_q <= 2'h0;
		else if (off_q != 2'h3)
			off_q <= off_q + 2'h1;
	end
	chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
	chk_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken during answer");
	chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	chk_unmapped_zero: assert property (s_axi_rvalid && s_axi_rresp == `ISC_RESP_SLVERR
		|-> s_axi_rdata == 32'h0) else $error("error read carries data");
	chk_stretch_off: assert property (
		!ss_q && !$past(ss_q) && !$past(ss_q, 2) && !$past(ss_q, 3)
		|-> !scl_oe) else $error("clock held");
	chk_stretch_hold: assert property (
		(en_q && ss_q && !scl_i) [*6] |-> ##[0:4] scl_oe) else $error("clock not held");
	chk_disabled_quiet: assert property (
		off_q == 2'h3 |-> !scl_oe && !sda_oe) else $error("disabled slave drives");
	chk_sda_moves: assert property ($changed(sda_oe) |-> !scl_i)
		else $error("data moved with clock high");
endmodule : isc_slave_ctrl_checker

bind isc_slave_ctrl isc_slave_ctrl_checker u_chk (.*);

// file: verification/isc_i2c_master.sv
`timescale 1ns/1ps
module isc_i2c_master (
	output logic      scl_m,
	output logic      sda_m,
	input  wire logic scl,
	input  wire logic sda,
	output logic      stuck
);
	// lines released when idle, pull-ups give high
	initial begin
		scl_m = 1'b1;
		sda_m = 1'b1;
		stuck = 1'b0;
	end
	// high phase; a stretching slave is waited out, but not forever
	task automatic rise(input logic b, output logic r);
		sda_m = b;
		#31.25;
		scl_m = 1'b1;
		#31.25;
		for (int i = 0; i < 4000 && !scl; i++)
			#10;
		stuck |= !scl;
		r = sda;
		#31.25;
	endtask : rise
	task automatic fall;
		scl_m = 1'b0;
		#31.25;
	endtask : fall
	task automatic start;
		sda_m = 1'b1;
		scl_m = 1'b1;
		#62.5;
		sda_m = 1'b0;
		#31.25;
		fall();
	endtask : start
	task automatic stop;
		sda_m = 1'b0;
		#31.25;
		scl_m = 1'b1;
		#31.25;
		sda_m = 1'b1;
		#62.5;
	endtask : stop
	// msb first, then the slave's acknowledge
	task automatic wbyte(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			rise(b[i], r);
			fall();
		end
		rise(1'b1, r);
		ack = !r;
		fall();
	endtask : wbyte
	task automatic rbyte(input logic nack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			rise(1'b1, d[i]);
			fall();
		end
		rise(nack, r);
		fall();
	endtask : rbyte
endmodule : isc_i2c_master

// file: verification/tb_i2c_slave_control.sv
`timescale 1ns/1ps
`include "isc_params.svh"
module tb_i2c_slave_control;
	localparam logic [31:0] a_ct = `ISC_CTRL_ADDR;
	localparam logic [31:0] a_st = `ISC_STAT_ADDR;
	localparam logic [31:0] a_is = `ISC_ISTS_ADDR;
	localparam logic [31:0] a_im = `ISC_IMSK_ADDR;
	logic        clk_sys, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
	logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic        s_axi_rvalid, scl_o, scl_oe, sda_o, sda_oe, irq, scl_m, sda_m, stuck;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	int          fails, n_compared;
	wire         scl_i = scl_m & ~scl_oe;
	wire         sda_i = sda_m & ~sda_oe;
	isc_slave_ctrl DUT (.*);
	isc_i2c_master m (.scl(scl_i), .sda(sda_i), .*);
	initial clk_sys = 1'b0;
	always #5 clk_sys = ~clk_sys;
	task automatic stop_test;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : stop_test
	task automatic chk(input logic [31:0] got, exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	// bus master: hold each channel until its ready, bready until bvalid
	task automatic wr(input logic [31:0] a, d);
		int i;
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (i = 0; i < 99; i++) begin
			@(posedge clk_sys);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) begin
				s_axi_bready <= 1'b0;
				break;
			end
		end
		// let flops launched at the answer edge settle before callers look
		@(negedge clk_sys);
		chk(i < 99, 1);
	endtask : wr
	task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
		int i;
		@(posedge clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (i = 0; i < 99; i++) begin
			@(posedge clk_sys);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) begin
				s_axi_rready <= 1'b0;
				d = s_axi_rdata;
				r = s_axi_rresp;
				break;
			end
		end
		chk(i < 99, 1);
	endtask : rd
	task automatic rchk(input logic [31:0] a, msk, exp);
		logic [31:0] d;
		logic [1:0]  r;
		rd(a, d, r);
		chk(d & msk, exp);
	endtask : rchk
	// one write frame; second byte only when the first is expected to be acknowledged
	task automatic xfer(input logic [7:0] a0, a1, input logic e0, e1);
		logic ack;
		m.start();
		m.wbyte(a0, ack);
		chk(ack, e0);
		if (e0) begin
			m.wbyte(a1, ack);
			chk(ack, e1);
		end
		m.stop();
	endtask : xfer
	function automatic logic [31:0] gc_stat(input int k);
		return {22'h0, k == 0 ? `ISC_GCID_PROG : k == 1 ? `ISC_GCID_ALT : `ISC_GCID_RST, 8'h80};
	endfunction : gc_stat
	function automatic logic [7:0] ten_hi(input logic [9:0] a);
		return {`ISC_TEN_PREFIX, a[9:8], 1'b0};
	endfunction : ten_hi
	initial begin
		logic [31:0] d;
		logic [1:0]  r;
		logic [9:0]  own;
		logic [7:0]  b;
		logic [7:0]  alt;
		logic        ack;
		rst_n = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
		s_axi_wstrb = 4'hf;
		d = $urandom(32'h37e4a47e);
		repeat (20) @(posedge clk_sys);
		rst_n <= 1'b1;
		rchk(a_ct, 32'hffff, 32'h0);
		rchk(a_st, 32'hffff, 32'h0);
		wr(a_ct, 32'hffff);
		rchk(a_ct, 32'hffffffff, {16'h0, `ISC_C_MASK});
		rd(32'hffff0a00, d, r);
		chk({r, d[29:0]}, {`ISC_RESP_SLVERR, 30'h0});
		$display("test registers done");
		own = {3'($urandom), 7'($urandom_range(119, 8))};
		wr(`ISC_OWN_ADDR, 32'(own));
		wr(a_ct, 32'h0);
		wr(a_im, 32'hf);
		xfer({own[6:0], 1'b0}, 8'h0, 1'b0, 1'b0);
		chk(irq, 0);
		$display("test disabled done");
		wr(a_ct, 32'h1);
		wr(a_im, 32'h0);
		b = 8'($urandom);
		xfer({own[6:0], 1'b0}, b, 1'b1, 1'b1);
		rchk(`ISC_RXD_ADDR, 32'hff, 32'(b));
		chk(irq, 0);
		rchk(a_is, 32'h2, 32'h2);
		wr(a_im, 32'hf);
		chk(irq, 1);
		wr(a_is, 32'hf);
		chk(irq, 0);
		xfer(ten_hi(own), own[7:0], 1'b0, 1'b0);
		wr(a_ct, 32'h3);
		xfer(ten_hi(own), own[7:0], 1'b1, 1'b1);
		xfer({own[6:0], 1'b0}, 8'h0, 1'b0, 1'b0);
		$display("test addressing done");
		alt = {7'($urandom), 1'b1};
		wr(`ISC_ALT_ADDR, 32'(alt));
		for (int k = 0; k < 3; k++) begin
			b = k == 0 ? `ISC_GC_PROG : k == 1 ? alt : `ISC_GC_RESET;
			wr(a_ct, k == 1 ? 32'hd : 32'h5);
			xfer(`ISC_GC_ADDR, b, 1'b1, 1'b1);
			rchk(a_st, 32'h380, gc_stat(k));
			chk(irq, 1);
			wr(`ISC_OWN_ADDR, 32'(own));
			wr(a_ct, 32'h15);
			wr(a_ct, 32'h5);
			rchk(a_st, 32'h380, 32'h0);
			wr(a_is, 32'hf);
		end
		$display("test general call done");
		for (int k = 0; k < 2; k++) begin
			d = $urandom;
			wr(`ISC_TXD_ADDR, d);
			wr(a_ct, k ? 32'h1 : 32'h21);
			wr(a_is, 32'hf);
			m.start();
			for (int i = 6; i >= 0; i--) begin
				m.rise(own[i], ack);
				m.fall();
			end
			m.rise(1'b1, ack);
			#100;
			chk(irq, k == 0);
			m.fall();
			#100;
			chk(irq, 1);
			m.rise(1'b1, ack);
			chk(ack, 0);
			m.fall();
			m.rbyte(1'b1, b);
			chk(b, d[7:0]);
			m.stop();
		end
		$display("test transmit done");
		wr(a_ct, 32'h41);
		repeat (8) @(posedge clk_sys);
		chk(scl_oe, 0);
		fork
			xfer({own[6:0], 1'b0}, 8'h5a, 1'b1, 1'b1);
			begin
				#1000;
				chk(scl_i, 0);
				wr(a_ct, 32'h1);
			end
		join
		chk(stuck, 0);
		$display("test stretch done");
		stop_test();
	end
endmodule : tb_i2c_slave_control
